// >>> fcw_pkg.sv
// Purpose: shared constants for the flash command/wrap/ecc configuration link
// Assumes: one clock, 8-bit link fields, 32-bit register bus on the host end
// Notes:   register indices on the link and bus offsets are fixed here
package fcw_pkg;
   // link opcodes
   localparam logic [7:0] OP_RD_ANY   = 8'h65;
   localparam logic [7:0] OP_WR_ANY   = 8'h71;
   localparam logic [7:0] OP_SET_BL   = 8'hC0;
   localparam logic [7:0] OP_ECC_RD0  = 8'h18;
   localparam logic [7:0] OP_ECC_RD1  = 8'h19;
   localparam logic [7:0] OP_RESUME30 = 8'h30;
   localparam logic [7:0] OP_RST_F0   = 8'hF0;
   localparam logic [7:0] OP_RST_EN   = 8'h66;
   localparam logic [7:0] OP_RST      = 8'h99;
   localparam logic [7:0] OP_PROG     = 8'h02;
   localparam logic [7:0] OP_ER_PARAM = 8'h20;
   localparam logic [7:0] OP_ER_SECT  = 8'hD8;
   localparam logic [7:0] OP_ER_BULK0 = 8'h60;
   localparam logic [7:0] OP_ER_BULK1 = 8'hC7;
   localparam logic [7:0] OP_RD_NORM  = 8'h03;
   localparam logic [7:0] OP_RD_FAST  = 8'h0B;
   localparam logic [7:0] OP_RD_QIO   = 8'hEB;
   localparam logic [7:0] OP_RD_DQIO  = 8'hED;
   // register indices carried in the link address field
   localparam logic [7:0] RI_CB_BOOT  = 8'h00;
   localparam logic [7:0] RI_CB       = 8'h01;
   localparam logic [7:0] RI_BW_BOOT  = 8'h02;
   localparam logic [7:0] RI_BW       = 8'h03;
   // command-behaviour field positions
   localparam int CB_BLANK   = 5;
   localparam int CB_PWRAP   = 4;
   localparam int CB_PARAM   = 3;
   localparam int CB_RESUME  = 2;
   localparam int CB_LEGRST  = 0;
   localparam logic [7:0] CB_MASK     = 8'h3D;
   localparam logic [7:0] CB_RESET    = 8'h00;
   // burst-wrap field positions
   localparam int BW_DRV_LSB = 5;
   localparam int BW_WRAP_N  = 4;
   localparam int BW_WL_LSB  = 0;
   localparam logic [7:0] BW_MASK     = 8'hF3;
   localparam logic [7:0] BW_RESET    = 8'h10;
   localparam logic [7:0] ECC_MASK    = 8'h07;
   // host bus offsets and responses
   localparam logic [3:0] AX_CMD      = 4'h0;
   localparam logic [3:0] AX_STAT     = 4'h4;
   localparam int ST_BUSY    = 8;
   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> fcw_link_if.sv
// Purpose: command link between host controller and configuration device
// Assumes: both ends on sys_clk, one request outstanding at a time
// Notes:   every request is answered by exactly one rsp_valid pulse
`timescale 1ns/1ps
interface fcw_link_if (
   input wire logic sys_clk  // shared clock
);
   logic       req;        // one-cycle request
   logic [7:0] op;         // opcode
   logic [7:0] addr;       // register index or ecc unit
   logic [7:0] wdata;      // write data
   logic       rsp_valid;  // one-cycle answer
   logic [7:0] rsp_data;   // read data
   modport host (output req, op, addr, wdata, input rsp_valid, rsp_data);
   modport dev  (input req, op, addr, wdata, output rsp_valid, rsp_data);
endinterface

// >>> fcw_dev.sv
// Purpose: configuration device end: command-behaviour, burst-wrap, ecc status
// Assumes: host keeps one request outstanding; array side on same clock
// Notes:   command-behaviour boot copy sets bits one way only, like one-time cells; burst-wrap boot is overwritten
//
// Contract
// - host reads/writes config registers by generic commands
// - any reset reloads command-behaviour from boot copy
// - blank check: failed prior erase erases unconditionally
// - blank check: erase on zero, else skip
// - blank check covers all erases; off means erase
// - page wrap bit selects 256 or 512 buffer
// - parameter bit selects hybrid or uniform map
// - parameter bit changes only through boot copy
// - opcode 30h resume or clear status by select
// - F0h resets only while legacy enable set
// - 66h then 99h always resets
// - burst wrap only for main array reads
// - any reset copies burst-wrap boot to working
// - set-burst-length command writes working burst-wrap
// - wrap enable low wraps quad reads only
// - wrap length codes give 8 to 64 bytes
// - three-bit drive code, default zero
// - ecc read with unit returns its status
// - ecc status read-only, reserved bits low
// - bit 2 flags check code error
// - bit 1 corrected, bit 0 ecc off
// - software ignores ecc reserved bits
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fcw_dev (
   input  wire logic   sys_clk,          // 200 MHz clock
   input  wire logic   resetn,           // async reset, active low
   fcw_link_if.dev     lk,               // link to host
   input  wire logic   sector_erase_ok,  // last erase of sector completed
   input  wire logic   sector_blank,     // sector read found no zero bit
   input  wire logic   pb_load,          // one buffer byte loaded
   input  wire logic [2:0] ecc_flags,    // status of unit on ecc_unit
   output logic [7:0]  ecc_unit,         // selected ecc unit
   output logic        erase_start,      // pulse: begin erase
   output logic        erase_skip,       // pulse: erase skipped, blank
   output logic [8:0]  pb_addr,          // buffer load address
   output logic        param_overlay,    // 4-KB sectors in map
   output logic        resume_pulse,     // pulse: program/erase resume
   output logic        clr_stat_pulse,   // pulse: clear status
   output logic        soft_rst_pulse,   // pulse: software reset done
   output logic        arr_rd_start,     // pulse: main array read begins
   output logic        rd_wrap,          // that read wraps
   output logic [6:0]  rd_wrap_bytes,    // burst length in bytes
   output logic [2:0]  drive_code,       // output drive strength
   output logic        blank_check_en    // blank check active
);
   typedef struct packed {
      logic [7:0] cb_boot;
      logic [7:0] cb;
      logic [7:0] bw_boot;
      logic [7:0] bw;
      logic       armed;
      logic       ecc_pend;
      logic [7:0] ecc_unit;
      logic [8:0] pb;
      logic       rsp_valid;
      logic [7:0] rsp_data;
      logic       erase_start;
      logic       erase_skip;
      logic       resume;
      logic       clr_stat;
      logic       soft_rst;
      logic       rd_start;
      logic       rd_wrap;
      logic [6:0] rd_bytes;
   } fcw_dev_st_t;

   fcw_dev_st_t s_r;
   fcw_dev_st_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // outputs come straight from the state register
   assign lk.rsp_valid     = s_r.rsp_valid;
   assign lk.rsp_data      = s_r.rsp_data;
   assign ecc_unit         = s_r.ecc_unit;
   assign erase_start      = s_r.erase_start;
   assign erase_skip       = s_r.erase_skip;
   assign pb_addr          = s_r.pb;
   assign param_overlay    = ~s_r.cb[fcw_pkg::CB_PARAM];
   assign resume_pulse     = s_r.resume;
   assign clr_stat_pulse   = s_r.clr_stat;
   assign soft_rst_pulse   = s_r.soft_rst;
   assign arr_rd_start     = s_r.rd_start;
   assign rd_wrap          = s_r.rd_wrap;
   assign rd_wrap_bytes    = s_r.rd_bytes;
   assign drive_code       = s_r.bw[fcw_pkg::BW_DRV_LSB +: 3];
   assign blank_check_en   = s_r.cb[fcw_pkg::CB_BLANK];

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt             = s_r;
      s_nxt.rsp_valid   = 1'b0;
      s_nxt.erase_start = 1'b0;
      s_nxt.erase_skip  = 1'b0;
      s_nxt.resume      = 1'b0;
      s_nxt.clr_stat    = 1'b0;
      s_nxt.soft_rst    = 1'b0;
      s_nxt.rd_start    = 1'b0;
      s_nxt.rd_wrap     = 1'b0;

      // ecc answer one cycle after the unit is presented to the array
      if (s_r.ecc_pend) begin
         s_nxt.ecc_pend  = 1'b0;
         s_nxt.rsp_valid = 1'b1;
         // reserved bits driven low, only three flags are live
         s_nxt.rsp_data  = {5'h00, ecc_flags};
      end

      // buffer pointer: 256 mode keeps the ninth bit clear
      if (pb_load) begin
         if (s_r.cb[fcw_pkg::CB_PWRAP]) begin
            s_nxt.pb = s_r.pb + 9'h001;
         end else begin
            s_nxt.pb = {1'b0, s_r.pb[7:0] + 8'h01};
         end
      end

      if (lk.req) begin
         // any command other than 66h drops the reset arm, 99h included
         s_nxt.armed     = 1'b0;
         s_nxt.rsp_valid = 1'b1;
         s_nxt.rsp_data  = 8'h00;
         unique case (lk.op)
            fcw_pkg::OP_RD_ANY: begin
               unique case (lk.addr)
                  fcw_pkg::RI_CB_BOOT: s_nxt.rsp_data = s_r.cb_boot;
                  fcw_pkg::RI_CB:      s_nxt.rsp_data = s_r.cb;
                  fcw_pkg::RI_BW_BOOT: s_nxt.rsp_data = s_r.bw_boot;
                  fcw_pkg::RI_BW:      s_nxt.rsp_data = s_r.bw;
                  default:             s_nxt.rsp_data = 8'h00;
               endcase
            end
            fcw_pkg::OP_WR_ANY: begin
               unique case (lk.addr)
                  fcw_pkg::RI_CB_BOOT: begin
                     // one-time cells only ever set
                     s_nxt.cb_boot = s_r.cb_boot | (lk.wdata & fcw_pkg::CB_MASK);
                     // boot programming is the only path to the parameter bit
                     s_nxt.cb[fcw_pkg::CB_PARAM] = s_nxt.cb_boot[fcw_pkg::CB_PARAM];
                  end
                  fcw_pkg::RI_CB: begin
                     s_nxt.cb = lk.wdata & fcw_pkg::CB_MASK;
                     s_nxt.cb[fcw_pkg::CB_PARAM] = s_r.cb[fcw_pkg::CB_PARAM];
                  end
                  fcw_pkg::RI_BW_BOOT: begin
                     s_nxt.bw_boot = lk.wdata & fcw_pkg::BW_MASK;
                  end
                  fcw_pkg::RI_BW: begin
                     s_nxt.bw = lk.wdata & fcw_pkg::BW_MASK;
                  end
                  default: begin
                  end
               endcase
            end
            fcw_pkg::OP_SET_BL: begin
               s_nxt.bw = lk.wdata & fcw_pkg::BW_MASK;
            end
            fcw_pkg::OP_ECC_RD0, fcw_pkg::OP_ECC_RD1: begin
               // answer held back a cycle so the array can look up the unit
               s_nxt.rsp_valid = 1'b0;
               s_nxt.ecc_pend  = 1'b1;
               s_nxt.ecc_unit  = lk.addr;
            end
            fcw_pkg::OP_RESUME30: begin
               s_nxt.resume   = s_r.cb[fcw_pkg::CB_RESUME];
               s_nxt.clr_stat = ~s_r.cb[fcw_pkg::CB_RESUME];
            end
            fcw_pkg::OP_RST_F0: begin
               s_nxt.soft_rst = s_r.cb[fcw_pkg::CB_LEGRST];
            end
            fcw_pkg::OP_RST_EN: begin
               s_nxt.armed = 1'b1;
            end
            fcw_pkg::OP_RST: begin
               s_nxt.soft_rst = s_r.armed;
            end
            fcw_pkg::OP_PROG: begin
               s_nxt.pb = 9'h000;
            end
            fcw_pkg::OP_ER_PARAM, fcw_pkg::OP_ER_SECT,
            fcw_pkg::OP_ER_BULK0, fcw_pkg::OP_ER_BULK1: begin
               // blank state is only trusted after a clean previous erase
               if (!s_r.cb[fcw_pkg::CB_BLANK]) begin
                  s_nxt.erase_start = 1'b1;
               end else if (!sector_erase_ok) begin
                  s_nxt.erase_start = 1'b1;
               end else if (sector_blank) begin
                  s_nxt.erase_skip = 1'b1;
               end else begin
                  s_nxt.erase_start = 1'b1;
               end
            end
            fcw_pkg::OP_RD_QIO, fcw_pkg::OP_RD_DQIO: begin
               s_nxt.rd_start = 1'b1;
               s_nxt.rd_wrap  = ~s_r.bw[fcw_pkg::BW_WRAP_N];
               s_nxt.rd_bytes = 7'h08 << s_r.bw[fcw_pkg::BW_WL_LSB +: 2];
            end
            fcw_pkg::OP_RD_NORM, fcw_pkg::OP_RD_FAST: begin
               // normal and fast reads raise rd_start but never wrap, so stay linear
               s_nxt.rd_start = 1'b1;
               s_nxt.rd_wrap  = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // software reset reloads working copies, overriding same-cycle writes
      if (s_nxt.soft_rst) begin
         s_nxt.cb = s_r.cb_boot;
         s_nxt.bw = s_r.bw_boot;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; power-on and hardware reset give the boot defaults
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r          <= '0;
         s_r.cb_boot  <= fcw_pkg::CB_RESET;
         s_r.cb       <= fcw_pkg::CB_RESET;
         s_r.bw_boot  <= fcw_pkg::BW_RESET;
         s_r.bw       <= fcw_pkg::BW_RESET;
         s_r.rd_bytes <= 7'h08;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// >>> fcw_host.sv
// Purpose: host controller: AXI4-Lite command/status to the link
// Assumes: one AXI write and one read at most in flight
// Notes:   command writes while busy are dropped with OKAY
`timescale 1ns/1ps
module fcw_host #(
   parameter int AW = 4                    // bus address width
) (
   input  wire logic          sys_clk,        // 200 MHz clock
   input  wire logic          resetn,         // async reset, active low
   fcw_link_if.host           lk,             // link to device
   input  wire logic [AW-1:0] s_axi_awaddr,   // write address
   input  wire logic          s_axi_awvalid,  // write address valid
   output logic               s_axi_awready,  // write address ready
   input  wire logic [31:0]   s_axi_wdata,    // write data
   input  wire logic [3:0]    s_axi_wstrb,    // byte enables
   input  wire logic          s_axi_wvalid,   // write data valid
   output logic               s_axi_wready,   // write data ready
   output logic [1:0]         s_axi_bresp,    // write response
   output logic               s_axi_bvalid,   // write response valid
   input  wire logic          s_axi_bready,   // write response ready
   input  wire logic [AW-1:0] s_axi_araddr,   // read address
   input  wire logic          s_axi_arvalid,  // read address valid
   output logic               s_axi_arready,  // read address ready
   output logic [31:0]        s_axi_rdata,    // read data
   output logic [1:0]         s_axi_rresp,    // read response
   output logic               s_axi_rvalid,   // read data valid
   input  wire logic          s_axi_rready    // read data ready
);
   typedef struct packed {
      logic          aw_got, w_got, awready, wready, bvalid, arready, rvalid;
      logic [1:0]    bresp, rresp;
      logic [AW-1:0] awaddr;
      logic [31:0]   wdata, rdata;
      logic [3:0]    wstrb;
      logic          busy, req, param_ref;
      logic [7:0]    op, addr, wdat, res;
   } fcw_host_st_t;

   fcw_host_st_t s_r;
   fcw_host_st_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready  = s_r.wready;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rresp   = s_r.rresp;
   assign s_axi_rdata   = s_r.rdata;
   assign lk.req        = s_r.req;
   assign lk.op         = s_r.op;
   assign lk.addr       = s_r.addr;
   assign lk.wdata      = s_r.wdat;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and link sequencer
   always_comb begin
      s_nxt     = s_r;
      s_nxt.req = 1'b0;
      // address and data taken in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = (s_r.awaddr == fcw_pkg::AX_CMD) ? fcw_pkg::RESP_OK : fcw_pkg::RESP_SLVERR;
         if (s_r.awaddr == fcw_pkg::AX_CMD && !s_r.busy && s_r.wstrb[2:0] == 3'h7) begin
            s_nxt.busy = 1'b1;
            s_nxt.req  = 1'b1;
            s_nxt.op   = s_r.wdata[7:0];
            s_nxt.addr = s_r.wdata[15:8];
            s_nxt.wdat = s_r.wdata[23:16];
            // never push a parameter bit that differs from the boot copy
            if (s_r.wdata[7:0] == fcw_pkg::OP_WR_ANY && s_r.wdata[15:8] == fcw_pkg::RI_CB) begin
               s_nxt.wdat[fcw_pkg::CB_PARAM] = s_r.param_ref;
            end
            // boot cells only set, so follow what this write adds to them
            if (s_r.wdata[15:0] == {fcw_pkg::RI_CB_BOOT, fcw_pkg::OP_WR_ANY}) begin
               s_nxt.param_ref = s_r.param_ref | s_r.wdata[16 + fcw_pkg::CB_PARAM];
            end
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

      // read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = fcw_pkg::RESP_OK;
         s_nxt.rdata  = 32'h0000_0000;
         if (s_axi_araddr == fcw_pkg::AX_STAT) begin
            s_nxt.rdata[fcw_pkg::ST_BUSY] = s_r.busy;
            s_nxt.rdata[7:0]              = s_r.res;
         end else if (s_axi_araddr == fcw_pkg::AX_CMD) begin
            s_nxt.rdata[23:0] = {s_r.wdat, s_r.addr, s_r.op};
         end else begin
            s_nxt.rresp = fcw_pkg::RESP_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // link answer closes the command
      if (lk.rsp_valid && s_r.busy) begin
         s_nxt.busy = 1'b0;
         s_nxt.res  = lk.rsp_data;
         if (s_r.op == fcw_pkg::OP_ECC_RD0 || s_r.op == fcw_pkg::OP_ECC_RD1) begin
            s_nxt.res = lk.rsp_data & fcw_pkg::ECC_MASK;
         end
         if (s_r.op == fcw_pkg::OP_RD_ANY &&
             (s_r.addr == fcw_pkg::RI_CB || s_r.addr == fcw_pkg::RI_CB_BOOT)) begin
            s_nxt.param_ref = lk.rsp_data[fcw_pkg::CB_PARAM];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r         <= '0;
         s_r.awready <= 1'b1;
         s_r.wready  <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// >>> fcw_checker.sv
// Purpose: link assertions between host and device ends
// Assumes: one clock, one request outstanding at a time
// Notes:   sees only the interface signals, no design internals
`timescale 1ns/1ps
module fcw_checker (
   input wire logic       sys_clk,    // shared clock
   input wire logic       resetn,     // async reset, active low
   input wire logic       req,        // request pulse
   input wire logic [7:0] op,         // opcode, held until next request
   input wire logic [7:0] addr,       // register index or ecc unit
   input wire logic [7:0] wdata,      // write data
   input wire logic       rsp_valid,  // answer pulse
   input wire logic [7:0] rsp_data    // answer data
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // ecc reads answer a cycle later than everything else
   wire ecc = (op == 8'h18) || (op == 8'h19);
   ////////////////////////////////////////////////////////////////////////////
   // parameter bit as programmed into the boot copy; only ever set
   logic boot_p;
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn) boot_p <= 1'b0;
      else if (req && op == 8'h71 && addr == 8'h00) boot_p <= boot_p | wdata[3];
   ////////////////////////////////////////////////////////////////////////////
   chk_plain_answer: assert property (req && !ecc |=> rsp_valid)
      else $error("plain request not answered next cycle");
   chk_ecc_answer: assert property (req && ecc |=> !rsp_valid ##1 rsp_valid)
      else $error("ecc read not answered two cycles later");
   chk_ecc_reserved: assert property (rsp_valid && ecc |-> rsp_data[7:3] == 5'h00)
      else $error("ecc status upper bits not zero");
   chk_cb_reserved: assert property (req && op == 8'h65 && addr[7:1] == 7'h00
      |=> (rsp_data & ~fcw_pkg::CB_MASK) == 8'h00)
      else $error("command behaviour reserved bits set");
   chk_bw_reserved: assert property (req && op == 8'h65 && addr[7:1] == 7'h01
      |=> rsp_data[3:2] == 2'h0)
      else $error("burst wrap reserved bits set");
   chk_one_answer: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer pulse longer than one cycle");
   chk_answer_cause: assert property (rsp_valid |-> $past(req) || $past(req, 2))
      else $error("answer without a request");
   chk_unknown_zero: assert property (req && op == 8'h00
      |=> rsp_valid && rsp_data == 8'h00)
      else $error("unknown opcode answered nonzero");
   chk_param_follow: assert property (req && op == 8'h71 && addr == 8'h01
      |-> wdata[3] == boot_p)
      else $error("parameter bit written unlike boot copy");
endmodule

// >>> tb.sv
// Purpose: self-checking bench for host and device ends of the link
// Assumes: 200 MHz sys_clk, random data from a fixed-seed lfsr
// Notes:   side pulses are captured in the link answer cycle
`timescale 1ns/1ps
module tb;
   logic        sys_clk = 0, resetn = 0, er_ok = 0, blank = 0, pb_load = 0;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [2:0]  flags = 0, drv;
   logic [7:0]  ecc_unit, res, v;
   logic [8:0]  pb_addr;
   logic        ovl, bc_en;
   logic [6:0]  wbytes, seen;
   wire  [6:0]  pl;
   logic [31:0] lfsr = 32'hB92D;
   int          n_mismatch = 0, n_compared = 0;
   always #2.5 sys_clk = ~sys_clk;
   fcw_link_if lk (.sys_clk(sys_clk));
   // pulses land in the same cycle as the answer
   always @(posedge sys_clk) if (lk.rsp_valid) seen <= pl;
   fcw_host i_fcw_host (.sys_clk, .resetn, .lk(lk), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fcw_dev i_fcw_dev (.sys_clk, .resetn, .lk(lk), .sector_erase_ok(er_ok),
      .sector_blank(blank), .pb_load, .ecc_flags(flags), .ecc_unit, .pb_addr,
      .erase_start(pl[6]), .erase_skip(pl[5]), .param_overlay(ovl),
      .resume_pulse(pl[4]), .clr_stat_pulse(pl[3]), .soft_rst_pulse(pl[2]),
      .arr_rd_start(pl[1]), .rd_wrap(pl[0]), .rd_wrap_bytes(wbytes),
      .drive_code(drv), .blank_check_en(bc_en));
   fcw_checker i_fcw_checker (.sys_clk, .resetn, .req(lk.req), .op(lk.op), .addr(lk.addr),
      .wdata(lk.wdata), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   // skip only with blank check on, a clean last erase and a blank sector
   function automatic logic [1:0] exp_erase(input logic [2:0] c);
      return (c == 3'h7) ? 2'h1 : 2'h2;
   endfunction
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // bounded wait: a hang counts as a mismatch and ends the run
   task automatic tick(inout int k);
      @(posedge sys_clk);
      k++;
      if (k > 99) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] wd);
      int k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         tick(k);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic axr(input logic [3:0] a);
      int k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         tick(k);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // one link command, then poll status until the host is idle
   task automatic cmd(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] wd);
      int k = 0;
      axw(fcw_pkg::AX_CMD, {8'h00, wd, ad, op});
      chk("bresp", r, fcw_pkg::RESP_OK);
      do begin
         axr(fcw_pkg::AX_STAT);
         k++;
      end while (d[fcw_pkg::ST_BUSY] && k < 50);
      chk("busy", d[fcw_pkg::ST_BUSY], 0);
      if (d[fcw_pkg::ST_BUSY]) results();
      res = d[7:0];
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1;
      @(posedge sys_clk);
      chk("ovl", ovl, 1);
      chk("drv", drv, 0);
      for (int i = 0; i < 4; i++) begin
         cmd(8'h65, i[7:0], 8'h00);
         chk("rst", res, i[1] ? 8'h10 : 8'h00);
         chk("read_any_reg_cmd", seen[1], 0);
      end
      cmd(8'h00, 8'h00, 8'h00);
      chk("unk", res, 8'h00);
      axw(4'h4, 32'h0);
      chk("wr4", r, fcw_pkg::RESP_SLVERR);
      axr(4'h8);
      chk("rd8", r, fcw_pkg::RESP_SLVERR);
      // random writes: plain write on command behaviour, both paths on burst wrap
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         cmd(8'h71, 8'h01, v);
         cmd(8'h65, 8'h01, 8'h00);
         chk("cb", res, v & fcw_pkg::CB_MASK & 8'hF7);
         chk("bc", bc_en, v[5]);
         v = rnd();
         cmd(i[0] ? 8'hC0 : 8'h71, 8'h03, v);
         cmd(8'h65, 8'h03, 8'h00);
         chk("bw", res, v & fcw_pkg::BW_MASK);
         chk("drv", drv, v[7:5]);
      end
      // every erase opcode against blank check, prior erase and blank sector
      for (int i = 0; i < 32; i++) begin
         cmd(8'h71, 8'h01, {2'h0, i[4], 5'h00});
         er_ok <= i[3];
         blank <= i[2];
         case (i[1:0])
            0: v = 8'h20;
            1: v = 8'hD8;
            2: v = 8'h60;
            default: v = 8'hC7;
         endcase
         cmd(v, 8'h00, 8'h00);
         chk("erase", seen[6:5], exp_erase(i[4:2]));
      end
      for (int i = 0; i < 4; i++) begin
         cmd(8'h71, 8'h01, {5'h00, i[0], 1'b0, i[1]});
         cmd(8'h30, 8'h00, 8'h00);
         chk("op30", seen[4:3], i[0] ? 2'h2 : 2'h1);
         cmd(8'hF0, 8'h00, 8'h00);
         chk("f0", seen[2], i[1]);
         cmd(8'h65, 8'h01, 8'h00);
         chk("cfg", res, i[1] ? 8'h00 : {5'h00, i[0], 2'h0});
      end
      v = rnd();
      cmd(8'h71, 8'h02, v);
      cmd(8'h71, 8'h03, 8'h00);
      cmd(8'h66, 8'h00, 8'h00);
      cmd(8'h99, 8'h00, 8'h00);
      chk("sr", seen[2], 1);
      cmd(8'h65, 8'h03, 8'h00);
      chk("bwb", res, v & fcw_pkg::BW_MASK);
      // quad reads wrap only when enabled; other array reads stay sequential
      for (int i = 0; i < 8; i++) begin
         cmd(8'hC0, 8'h03, {3'h0, i[2], 2'h0, i[1:0]});
         cmd(i[0] ? 8'hEB : 8'hED, 8'h00, 8'h00);
         chk("wrap", seen[1:0], {1'b1, !i[2]});
         if (!i[2]) chk("len", wbytes, 7'h08 << i[1:0]);
         cmd(i[0] ? 8'h03 : 8'h0B, 8'h00, 8'h00);
         chk("seq", seen[1:0], 2'h2);
      end
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         flags <= v[2:0];
         cmd(i[0] ? 8'h19 : 8'h18, v, 8'h00);
         chk("ecc", res, {5'h00, v[2:0]});
         chk("unit", ecc_unit, v);
      end
      // 300 loads: 256 mode wraps to 44, 512 mode keeps counting
      for (int i = 0; i < 2; i++) begin
         cmd(8'h71, 8'h01, {3'h0, i[0], 4'h0});
         cmd(8'h02, 8'h00, 8'h00);
         pb_load <= 1;
         repeat (300) @(posedge sys_clk);
         pb_load <= 0;
         @(posedge sys_clk);
         chk("pb", pb_addr, i ? 9'h12C : 9'h02C);
      end
      cmd(8'h71, 8'h00, 8'h08);
      cmd(8'h71, 8'h01, 8'h00);
      cmd(8'h65, 8'h01, 8'h00);
      chk("param", res, 8'h08);
      chk("ovl", ovl, 0);
      results();
   end
endmodule
